// ==== rtl/tc01_top.sv ====
/*
 * Dual 16-bit timer/counter with AHB-Lite register slave, gating by
 * the external interrupt pins and a maskable interrupt output.
 * Assumes pins synchronous to hclk, one AHB-Lite master, single word
 * transfers, and a core that pulses vector_ack_x when it vectors.
 */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "tc01_regs.svh"

module tc01_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        count_input_0,
	input  wire logic        count_input_1,
	input  wire logic        ext_irq_pin_0,
	input  wire logic        ext_irq_pin_1,
	input  wire logic        vector_ack_0,
	input  wire logic        vector_ack_1,
	output logic             timer0_overflow_flag,
	output logic             timer1_overflow_flag,
	output logic             irq
);

	// ============================================================
	// State
	tc01_pkg::tc01_state_s s;
	tc01_pkg::tc01_state_s next_s;

	logic [1:0] gate_pin;
	logic [1:0] gate_ok;
	logic [1:0] fall_edge;
	logic [1:0] tick;
	logic [1:0] vec_ack;
	logic [7:0] wr_index;
	logic [7:0] ad_index;
	logic [7:0] wdata;
	logic       wr_en;

	assign gate_pin = {ext_irq_pin_1, ext_irq_pin_0};
	assign vec_ack  = {vector_ack_1, vector_ack_0};
	assign wr_index = s.ap_index;
	assign ad_index = haddr[`TC01_ADDR_IDX_HI:`TC01_ADDR_IDX_LO];
	assign wdata    = hwdata[7:0];
	assign wr_en    = s.ap_valid & s.ap_write;

	// ============================================================
	// Per unit enable and count pulse
	for (genvar g = 0; g < 2; g++) begin : g_unit
		// Gating off leaves the run bit alone in charge
		assign gate_ok[g] = s.run[g] &
			(~s.mode[g * `TC01_MODE_STRIDE + `TC01_MODE_GATE] |
			gate_pin[g]);
		// Old sample high, new sample low: needs two cycles per edge
		assign fall_edge[g] = s.samp_old[g] & ~s.samp_new[g];
		assign tick[g] = gate_ok[g] &
			(s.mode[g * `TC01_MODE_STRIDE + `TC01_MODE_SRC] ?
			fall_edge[g] : 1'b1);
	end

	// ============================================================
	// Next state
	always_comb begin
		tc01_pkg::tc01_mode_e mode_sel;
		logic [1:0]           ovf;
		logic [1:0]           flag_base;
		logic [1:0]           int_clr;
		logic [15:0]          word;
		next_s    = s;
		ovf       = 2'b00;
		int_clr   = 2'b00;
		flag_base = s.flag;
		word      = 16'h0000;
		mode_sel  = tc01_pkg::TC01_MODE_PRESCALE;

		// Pins are synchronous; one sample per cycle
		next_s.samp_new = {count_input_1, count_input_0};
		next_s.samp_old = s.samp_new;

		// Counting
		for (int i = 0; i < 2; i++) begin
			mode_sel = tc01_pkg::tc01_mode_e'(
				s.mode[i * `TC01_MODE_STRIDE + `TC01_MODE_SEL_LSB +: 2]);
			unique case (mode_sel)
				tc01_pkg::TC01_MODE_PRESCALE: begin
					if (tick[i]) begin
						// Upper three low bits are left untouched
						next_s.low_byte[i][4:0] = s.low_byte[i][4:0] +
							`TC01_PRESCALE_ONE;
						if (s.low_byte[i][4:0] == `TC01_PRESCALE_MAX) begin
							next_s.high_byte[i] = s.high_byte[i] +
								`TC01_BYTE_ONE;
							if (s.high_byte[i] == `TC01_BYTE_MAX) begin
								ovf[i] = 1'b1;
							end
						end
					end
				end
				tc01_pkg::TC01_MODE_CASCADE: begin
					if (tick[i]) begin
						word = {s.high_byte[i], s.low_byte[i]} +
							`TC01_WORD_ONE;
						next_s.high_byte[i] = word[15:8];
						next_s.low_byte[i]  = word[7:0];
						if ({s.high_byte[i], s.low_byte[i]} ==
							`TC01_WORD_MAX) begin
							ovf[i] = 1'b1;
						end
					end
				end
				tc01_pkg::TC01_MODE_RELOAD: begin
					if (tick[i]) begin
						if (s.low_byte[i] == `TC01_BYTE_MAX) begin
							next_s.low_byte[i] = s.high_byte[i];
							ovf[i] = 1'b1;
						end else begin
							next_s.low_byte[i] = s.low_byte[i] +
								`TC01_BYTE_ONE;
						end
					end
				end
				tc01_pkg::TC01_MODE_SPLIT: begin
					// Unit 1 in this mode simply holds its count
					if (i == 0) begin
						if (tick[0]) begin
							next_s.low_byte[0] = s.low_byte[0] +
								`TC01_BYTE_ONE;
							if (s.low_byte[0] == `TC01_BYTE_MAX) begin
								ovf[0] = 1'b1;
							end
						end
						// High byte: cycles only, unit 1 run bit, no gate
						if (s.run[1]) begin
							next_s.high_byte[0] = s.high_byte[0] +
								`TC01_BYTE_ONE;
							if (s.high_byte[0] == `TC01_BYTE_MAX) begin
								ovf[1] = 1'b1;
							end
						end
					end
				end
			endcase
		end

		// Register writes land after counting so software wins over the count bytes
		if (wr_en) begin
			case (wr_index)
				`TC01_IDX_CONTROL: begin
					next_s.run[0]   = wdata[`TC01_CTRL_RUN0];
					next_s.run[1]   = wdata[`TC01_CTRL_RUN1];
					flag_base[0]    = wdata[`TC01_CTRL_FLAG0];
					flag_base[1]    = wdata[`TC01_CTRL_FLAG1];
					next_s.ext_cfg  =
						wdata[`TC01_CTRL_EXT_HI:`TC01_CTRL_EXT_LO];
				end
				`TC01_IDX_MODE:       next_s.mode = wdata;
				`TC01_IDX_LOW0:       next_s.low_byte[0] = wdata;
				`TC01_IDX_LOW1:       next_s.low_byte[1] = wdata;
				`TC01_IDX_HIGH0:      next_s.high_byte[0] = wdata;
				`TC01_IDX_HIGH1:      next_s.high_byte[1] = wdata;
				`TC01_IDX_INT_CLEAR:  int_clr = wdata[1:0];
				`TC01_IDX_INT_ENABLE: next_s.int_enable = wdata[1:0];
				default: begin
				end
			endcase
		end

		// A new overflow beats a clear in the same cycle
		next_s.flag = (flag_base & ~vec_ack) | ovf;
		next_s.int_status = (s.int_status & ~int_clr) | ovf;

		// Bus: reads take one wait cycle so hrdata comes from a flop
		next_s.rd_done = s.ap_valid & ~s.ap_write & ~s.rd_done;
		if (s.ap_valid & ~s.ap_write & ~s.rd_done) begin
			case (s.ap_index)
				`TC01_IDX_CONTROL: next_s.hrdata = {24'h000000, s.flag[1],
					s.run[1], s.flag[0], s.run[0], s.ext_cfg};
				`TC01_IDX_MODE:  next_s.hrdata = {24'h000000, s.mode};
				`TC01_IDX_LOW0:  next_s.hrdata = {24'h000000, s.low_byte[0]};
				`TC01_IDX_LOW1:  next_s.hrdata = {24'h000000, s.low_byte[1]};
				`TC01_IDX_HIGH0: next_s.hrdata = {24'h000000, s.high_byte[0]};
				`TC01_IDX_HIGH1: next_s.hrdata = {24'h000000, s.high_byte[1]};
				`TC01_IDX_INT_STATUS:
					next_s.hrdata = {30'h00000000, s.int_status};
				`TC01_IDX_INT_ENABLE:
					next_s.hrdata = {30'h00000000, s.int_enable};
				default: next_s.hrdata = 32'h00000000;
			endcase
		end
		if (hready) begin
			next_s.ap_valid = hsel & htrans[1];
			next_s.ap_write = hwrite;
			next_s.ap_index = ad_index;
		end
	end

	// ============================================================
	// Registers; clock enable low freezes everything
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// ============================================================
	// Outputs
	assign hreadyout = ~(s.ap_valid & ~s.ap_write & ~s.rd_done);
	assign hresp     = 1'b0;
	assign hrdata    = s.hrdata;
	assign timer0_overflow_flag = s.flag[0];
	assign timer1_overflow_flag = s.flag[1];
	assign irq = |(s.int_status & s.int_enable);

endmodule : tc01_top

// ==== rtl/tc01_regs.svh ====
/*
 * Register indices, field positions, reset values and limits of the
 * dual timer/counter block.
 * Assumes a 32-bit AHB-Lite bus with each register on its own word,
 * byte address = index * 4.
 */
`ifndef TC01_REGS_SVH
`define TC01_REGS_SVH

// ============================================================
// Register indices (byte address is index * 4)
`define TC01_IDX_CONTROL     8'h88
`define TC01_IDX_MODE        8'h89
`define TC01_IDX_LOW0        8'h8A
`define TC01_IDX_LOW1        8'h8B
`define TC01_IDX_HIGH0       8'h8C
`define TC01_IDX_HIGH1       8'h8D
`define TC01_IDX_INT_STATUS  8'h90
`define TC01_IDX_INT_CLEAR   8'h91
`define TC01_IDX_INT_ENABLE  8'h92

// ============================================================
// Address decode
`define TC01_ADDR_IDX_HI     9
`define TC01_ADDR_IDX_LO     2

// ============================================================
// Control register fields
`define TC01_CTRL_EXT_HI     3
`define TC01_CTRL_EXT_LO     0
`define TC01_CTRL_RUN0       4
`define TC01_CTRL_FLAG0      5
`define TC01_CTRL_RUN1       6
`define TC01_CTRL_FLAG1      7

// ============================================================
// Mode register fields, per unit offset by the stride
`define TC01_MODE_STRIDE     4
`define TC01_MODE_SEL_LSB    0
`define TC01_MODE_SRC        2
`define TC01_MODE_GATE       3

// ============================================================
// Counting limits and reset values
`define TC01_PRESCALE_MAX    5'h1F
`define TC01_PRESCALE_ONE    5'h01
`define TC01_BYTE_MAX        8'hFF
`define TC01_BYTE_ONE        8'h01
`define TC01_WORD_MAX        16'hFFFF
`define TC01_WORD_ONE        16'h0001
`define TC01_RESET_BYTE      8'h00

`endif

// ==== rtl/tc01_pkg.sv ====
/*
 * Types shared by the dual timer/counter block.
 * Assumes the constants of tc01_regs.svh for field positions.
 */
package tc01_pkg;

	// ============================================================
	// Counting modes
	typedef enum logic [1:0] {
		TC01_MODE_PRESCALE = 2'b00,
		TC01_MODE_CASCADE  = 2'b01,
		TC01_MODE_RELOAD   = 2'b10,
		TC01_MODE_SPLIT    = 2'b11
	} tc01_mode_e;

	typedef logic [1:0][7:0] tc01_bytes_t;

	// ============================================================
	// Whole state of the block
	typedef struct packed {
		tc01_bytes_t low_byte;
		tc01_bytes_t high_byte;
		logic [7:0]  mode;
		logic [1:0]  run;
		logic [1:0]  flag;
		logic [3:0]  ext_cfg;
		logic [1:0]  samp_new;
		logic [1:0]  samp_old;
		logic [1:0]  int_status;
		logic [1:0]  int_enable;
		logic        ap_valid;
		logic        ap_write;
		logic [7:0]  ap_index;
		logic        rd_done;
		logic [31:0] hrdata;
	} tc01_state_s;

endpackage : tc01_pkg

// ==== tb/tc01_properties.sv ====
/* Port checker for tc01_top, bound after the module.
 * Assumes one clock, hready fed back from hreadyout. */
`timescale 1ns/1ps
module tc01_properties (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        clk_en,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        vector_ack_0,
	input wire logic        vector_ack_1,
	input wire logic        timer0_overflow_flag,
	input wire logic        timer1_overflow_flag,
	input wire logic        irq
);
	// ====
	// Write data phase marker
	logic wr_dp;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_dp <= 1'h0;
		else if (clk_en)
			wr_dp <= hsel && htrans[1] && hready && hwrite;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_take(w);
		clk_en && hsel && htrans[1] && hready && hwrite == w;
	endsequence
	// Flags drop only by an ack or a bus write
	a_resp_okay: assert property (hresp == 1'h0)
		else $error("response not okay");
	a_read_wait: assert property (s_take(1'h0) |=> !hreadyout)
		else $error("read without wait state");
	a_wait_one: assert property (!hreadyout && clk_en |=> hreadyout)
		else $error("wait state too long");
	a_wait_cause: assert property ($fell(hreadyout) |-> $past(!hwrite))
		else $error("wait without read");
	a_write_nowait: assert property (s_take(1'h1) |=> hreadyout)
		else $error("write stalled");
	a_rdata_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_flag0_clear: assert property ($fell(timer0_overflow_flag) |->
		$past(vector_ack_0) || $past(wr_dp)) else $error("flag0 lost");
	a_flag1_clear: assert property ($fell(timer1_overflow_flag) |->
		$past(vector_ack_1) || $past(wr_dp)) else $error("flag1 lost");
	a_irq_rise: assert property ($rose(irq) |-> $past(wr_dp) ||
		$rose(timer0_overflow_flag) || $rose(timer1_overflow_flag))
		else $error("irq without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(wr_dp))
		else $error("irq dropped without write");
endmodule : tc01_properties

bind tc01_top tc01_properties i_tc01_properties (.hclk(hclk),
	.hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .vector_ack_0(vector_ack_0),
	.vector_ack_1(vector_ack_1), .irq(irq),
	.timer0_overflow_flag(timer0_overflow_flag),
	.timer1_overflow_flag(timer1_overflow_flag));

// ==== tb/tc01_pins.sv ====
/* Model of the count and gating pins.
 * Assumes calls right after a rising hclk edge. */
`timescale 1ns/1ps
module tc01_pins (
	input wire logic hclk,
	output logic     count_input_0,
	output logic     count_input_1,
	output logic     ext_irq_pin_0,
	output logic     ext_irq_pin_1
);
	// ====
	// Pins of both units idle: gating low stops either unit whose gate bit is set
	initial begin
		count_input_0 = 1'h1;
		count_input_1 = 1'h1;
		ext_irq_pin_0 = 1'h0;
		ext_irq_pin_1 = 1'h0;
	end
	task automatic falls(input int n);
		repeat (n) begin
			@(posedge hclk) count_input_0 <= 1'h0;
			@(posedge hclk) count_input_0 <= 1'h1;
		end
	endtask : falls
	task automatic gate(input logic v);
		@(posedge hclk) ext_irq_pin_0 <= v;
	endtask : gate
	task automatic falls1(input int n);
		repeat (n) begin
			@(posedge hclk) count_input_1 <= 1'h0;
			@(posedge hclk) count_input_1 <= 1'h1;
		end
	endtask : falls1
	task automatic timer1_gating(input logic v);
		@(posedge hclk) ext_irq_pin_1 <= v;
	endtask : timer1_gating
endmodule : tc01_pins

// ==== tb/tb_tc01_top.sv ====
/* Register level bench of tc01_top.
 * Assumes the pin model tc01_pins and the bound checker. */
`timescale 1ns/1ps
`include "tc01_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_tc01_top;
	// ====
	// Bus, pins and bookkeeping
	logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, rd_n;
	logic [1:0]  htrans = 2'h0;
	logic        vector_ack_0 = 1'h0, vector_ack_1 = 1'h0, rdy_n, irq_n;
	logic        clk_en = 1'h1, hresp_n;
	logic [1:0]  f_n;
	wire logic   hreadyout, irq, ci0, ci1, ep0, ep1;
	wire logic   hresp, flag0, flag1;
	wire logic [31:0] hrdata;
	int          n_mismatch = 0, compares = 0;
	logic [7:0]  t [4][8] = '{'{8'h0, 8'h01, 8'hFF, 8'hFF, 8'h01, 8'h00,
		8'h30, 8'h01}, '{8'h0, 8'h00, 8'h1E, 8'h05, 8'h00, 8'h06, 8'h10,
		8'h00}, '{8'h1, 8'h20, 8'hFF, 8'h80, 8'h81, 8'h80, 8'hC0, 8'h02},
		'{8'h1, 8'h30, 8'h10, 8'h22, 8'h10, 8'h22, 8'h40, 8'h00}};
	tc01_top i_tc01_top (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.count_input_0(ci0), .count_input_1(ci1), .ext_irq_pin_0(ep0),
		.ext_irq_pin_1(ep1), .vector_ack_0(vector_ack_0),
		.vector_ack_1(vector_ack_1), .timer0_overflow_flag(flag0),
		.timer1_overflow_flag(flag1), .irq(irq));
	tc01_pins i_tc01_pins (.hclk(hclk), .count_input_0(ci0),
		.count_input_1(ci1), .ext_irq_pin_0(ep0), .ext_irq_pin_1(ep1));
	initial begin
		forever #4 hclk = ~hclk;
	end
	// Mid-cycle copies keep edge sampling free of races
	always @(negedge hclk) begin
		rdy_n <= hreadyout;
		rd_n <= hrdata;
		irq_n <= irq;
		f_n <= {flag1, flag0};
		hresp_n <= hresp;
	end
	task automatic xfer(input logic w, input logic [7:0] i, d);
		hsel <= 1'h1;
		haddr <= {22'h0, i, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (!rdy_n);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (!rdy_n);
		rd = rd_n;
	endtask : xfer
	task automatic chk(input logic [7:0] i, e);
		xfer(1'h0, i, 8'h0);
		`CHK(rd, {24'h0, e})
	endtask : chk
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++) chk(8'h88 + i, 8'h00);
		xfer(1'h1, 8'h95, 8'hAA);
		chk(8'h95, 8'h00);
		xfer(1'h1, `TC01_IDX_INT_ENABLE, 8'h01);
		// Two counts between run write and gating stop
		foreach (t[r]) begin
			xfer(1'h1, `TC01_IDX_CONTROL, 8'h00);
			xfer(1'h1, 8'h8A + t[r][0], t[r][2]);
			xfer(1'h1, 8'h8C + t[r][0], t[r][3]);
			xfer(1'h1, `TC01_IDX_MODE, t[r][1]);
			xfer(1'h1, `TC01_IDX_CONTROL, t[r][0] ? 8'h40 : 8'h10);
			xfer(1'h1, `TC01_IDX_MODE, t[r][1] | (t[r][0] ? 8'h80 : 8'h08));
			chk(8'h8A + t[r][0], t[r][4]);
			chk(8'h8C + t[r][0], t[r][5]);
			chk(`TC01_IDX_CONTROL, t[r][6]);
			chk(`TC01_IDX_INT_STATUS, t[r][7]);
			`CHK(irq_n, t[r][7][0])
			`CHK(f_n, {t[r][6][7], t[r][6][5]})
			`CHK(hresp_n, 1'h0)
			xfer(1'h1, `TC01_IDX_INT_CLEAR, 8'h03);
			vector_ack_0 <= !t[r][0][0];
			vector_ack_1 <= t[r][0][0];
			@(posedge hclk);
			vector_ack_0 <= 1'h0;
			vector_ack_1 <= 1'h0;
			chk(`TC01_IDX_CONTROL, t[r][6] & 8'h50);
			`CHK(f_n, 2'h0)
			`CHK(irq_n, 1'h0)
		end
		xfer(1'h1, `TC01_IDX_CONTROL, 8'h00);
		xfer(1'h1, `TC01_IDX_LOW0, 8'h00);
		xfer(1'h1, `TC01_IDX_MODE, 8'h0D);
		xfer(1'h1, `TC01_IDX_CONTROL, 8'h10);
		i_tc01_pins.falls(2);
		i_tc01_pins.gate(1'h1);
		i_tc01_pins.falls(5);
		i_tc01_pins.gate(1'h0);
		i_tc01_pins.falls(2);
		chk(`TC01_IDX_LOW0, 8'h05);
		// Unit 1 as gated event counter
		xfer(1'h1, `TC01_IDX_LOW1, 8'h00);
		xfer(1'h1, `TC01_IDX_MODE, 8'hD0);
		xfer(1'h1, `TC01_IDX_CONTROL, 8'h40);
		i_tc01_pins.falls1(2);
		i_tc01_pins.timer1_gating(1'h1);
		i_tc01_pins.falls1(3);
		i_tc01_pins.timer1_gating(1'h0);
		i_tc01_pins.falls1(1);
		chk(`TC01_IDX_LOW1, 8'h03);
		// Clock enable low holds the count still
		xfer(1'h1, `TC01_IDX_CONTROL, 8'h00);
		xfer(1'h1, `TC01_IDX_MODE, 8'h01);
		xfer(1'h1, `TC01_IDX_LOW0, 8'h00);
		xfer(1'h1, `TC01_IDX_CONTROL, 8'h10);
		clk_en <= 1'h0;
		repeat (10) @(posedge hclk);
		clk_en <= 1'h1;
		xfer(1'h1, `TC01_IDX_CONTROL, 8'h00);
		chk(`TC01_IDX_LOW0, 8'h02);
		`CHK(f_n, 2'h0)
		print_verdict();
	end
endmodule : tb_tc01_top
